// file: src/gpio_match_pkg.sv
// Constants shared by the two-port GPIO block with pattern match and oscillator wake.
// Assumes a byte-wide special-function-register bus that can also write single bits.
package gpio_match_pkg;

  localparam logic [7:0] ADDR_PORT_ZERO_DATA          = 8'h80;
  localparam logic [7:0] ADDR_PORT_ONE_DATA           = 8'h90;
  localparam logic [7:0] ADDR_INTERNAL_OSC_CONTROL    = 8'hb2;
  localparam logic [7:0] ADDR_PORT_ZERO_DRIVE_MODE    = 8'ha4;
  localparam logic [7:0] ADDR_PORT_ONE_DRIVE_MODE     = 8'ha5;
  localparam logic [7:0] ADDR_PORT_ZERO_INPUT_MODE    = 8'hf1;
  localparam logic [7:0] ADDR_PORT_ONE_INPUT_MODE     = 8'hf2;
  localparam logic [7:0] ADDR_PORT_ZERO_COMPARE_VALUE = 8'hd7;
  localparam logic [7:0] ADDR_PORT_ONE_COMPARE_VALUE  = 8'hcf;
  localparam logic [7:0] ADDR_PORT_ZERO_COMPARE_MASK  = 8'hd9;
  localparam logic [7:0] ADDR_PORT_ONE_COMPARE_MASK   = 8'hd6;
  localparam logic [7:0] ADDR_EXTENDED_IRQ_ENABLE_TWO = 8'he7;

  localparam logic [7:0] RST_PORT_DATA     = 8'hff;
  localparam logic [7:0] RST_DRIVE_MODE    = 8'h00;
  localparam logic [7:0] RST_INPUT_MODE    = 8'hff;
  localparam logic [7:0] RST_COMPARE_VALUE = 8'h00;
  localparam logic [7:0] RST_COMPARE_MASK  = 8'h00;
  localparam logic [7:0] RST_IRQ_ENABLE    = 8'h00;
  localparam logic [1:0] RST_OSC_ENABLE    = 2'h3;
  localparam logic [2:0] RST_OSC_DIVIDE    = 3'h0;
  localparam logic [7:0] RST_READ_DATA     = 8'h00;

  localparam logic [1:0] OSC_ENABLE_ON      = 2'h3;
  localparam int         OSC_ENABLE_LSB     = 6;
  localparam int         OSC_SUSPEND_BIT    = 5;
  localparam int         OSC_DIVIDE_WIDTH   = 3;
  localparam int         MATCH_IRQ_ENABLE_BIT = 1;

  // State names differ from the controller's status port, so the port cannot hide them.
  typedef enum logic {osc_active, osc_halted} osc_state_t;

endpackage : gpio_match_pkg

// file: src/gpio_port_bank.sv
// One 8-bit port: pin synchroniser, readback, pattern mismatch and pin drive.
// Assumes pins are asynchronous and crossbar drive comes from core_clk logic.
module gpio_port_bank
  import gpio_match_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic [7:0] pin_in,
  input  wire logic [7:0] latch,
  input  wire logic [7:0] drive_mode,
  input  wire logic [7:0] input_mode,
  input  wire logic [7:0] compare_value,
  input  wire logic [7:0] compare_mask,
  input  wire logic [7:0] xbar_claim,
  input  wire logic [7:0] xbar_out,
  input  wire logic [7:0] xbar_oe,
  output logic      [7:0] pin_out,
  output logic      [7:0] pin_oe,
  output logic      [7:0] pin_level,
  output logic            mismatch
);

  logic [7:0] pin_meta;
  logic [7:0] pin_sync;

  always_ff @(posedge core_clk or posedge rst) begin // R16
    if (rst) begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  // Analog pins read as zero; digital pins show the pin even when the crossbar owns it.
  assign pin_level = pin_sync & input_mode; // R4 R7

  // Compared from the synchronised pins regardless of any crossbar setting, so peripheral pins still match.
  assign mismatch = (pin_sync & compare_mask) != (compare_value & compare_mask); // R8 R9 R16

  // A zero drives low on a digital pin; a one drives only in push-pull, else the pin floats.
  assign pin_out = (xbar_claim & xbar_out) | (~xbar_claim & latch); // R1
  assign pin_oe  = input_mode & ((xbar_claim & xbar_oe) | (~xbar_claim & (~latch | drive_mode))); // R6

endmodule : gpio_port_bank

// file: src/suspend_wake_ctrl.sv
// Internal oscillator suspend state and its wake sources.
// Assumes the comparator output is an asynchronous level and its enable is on core_clk.
module suspend_wake_ctrl
  import gpio_match_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       suspend_req,
  input  wire logic [1:0] osc_enable,
  input  wire logic       osc_is_system_clock,
  input  wire logic       port_zero_mismatch,
  input  wire logic       port_one_mismatch,
  input  wire logic       cmp_enable,
  input  wire logic       cmp_out_pin,
  output logic            osc_suspended,
  output logic            wake_event,
  output logic            osc_run,
  output logic            sys_clk_enable
);

  osc_state_t state;
  logic       cmp_meta;
  logic       cmp_sync;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmp_meta <= 1'b1;
      cmp_sync <= 1'b1;
    end else begin
      cmp_meta <= cmp_out_pin;
      cmp_sync <= cmp_meta;
    end
  end

  assign wake_event = port_zero_mismatch | port_one_mismatch | (cmp_enable & ~cmp_sync); // R13

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= osc_active;
    end else begin
      case (state)
        osc_active: begin
          if (suspend_req) begin // R12
            state <= osc_halted;
          end
        end
        osc_halted: begin
          // A fresh suspend write wins over a wake seen in the same cycle.
          if (wake_event && !suspend_req) begin // R11 R14
            state <= osc_active;
          end
        end
        default: begin
          state <= osc_active;
        end
      endcase
    end
  end

  assign osc_suspended  = (state == osc_halted);
  assign osc_run        = (osc_enable == OSC_ENABLE_ON) && !osc_suspended; // R12
  // The core only stalls, so it resumes at the instruction after the suspend write.
  assign sys_clk_enable = !(osc_suspended && osc_is_system_clock); // R12 R15

endmodule : suspend_wake_ctrl

// file: src/gpio_port_match_wake.sv
// Two GPIO ports on the special-function-register bus, port match event and suspend wake.
// Assumes the core drives one byte or bit access per cycle and gates its clock with sys_clk_enable.
//
// Summary of operation
// R1 - Free pins serve as software controlled GPIO.
// R2 - Port registers take byte and bit accesses.
// R3 - Written port value is held in latch.
// R4 - Plain read returns pin levels, crossbar regardless.
// R5 - Read-modify-write reads the latch, not pins.
// R6 - Zero drives low; one needs push-pull.
// R7 - Analog pins read zero, digital read level.
// R8 - Masked pin mismatch raises port match event.
// R9 - Match watches pins regardless of crossbar.
// R10 - Match interrupts only while enable bit set.
// R11 - Match wakes oscillator regardless of interrupt enable.
// R12 - Suspend bit write halts oscillator and clocks.
// R13 - Wake on port matches or comparator low.
// R14 - Any wake resumes oscillator, core, peripherals.
// R15 - Core continues after the suspend write.
// R16 - Pins synchronised; match compare is combinational.
module gpio_port_match_wake
  import gpio_match_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic       sfr_rmw,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_bit_wr,
  input  wire logic [2:0] sfr_bit_sel,
  input  wire logic       sfr_bit_val,
  output logic      [7:0] sfr_rdata,
  input  wire logic [7:0] port_zero_pin_in,
  output logic      [7:0] port_zero_pin_out,
  output logic      [7:0] port_zero_pin_oe,
  input  wire logic [7:0] port_one_pin_in,
  output logic      [7:0] port_one_pin_out,
  output logic      [7:0] port_one_pin_oe,
  input  wire logic [7:0] port_zero_xbar_claim,
  input  wire logic [7:0] port_zero_xbar_out,
  input  wire logic [7:0] port_zero_xbar_oe,
  input  wire logic [7:0] port_one_xbar_claim,
  input  wire logic [7:0] port_one_xbar_out,
  input  wire logic [7:0] port_one_xbar_oe,
  input  wire logic       cmp_enable,
  input  wire logic       cmp_out_pin,
  input  wire logic       osc_is_system_clock,
  output logic            match_event,
  output logic            match_irq,
  output logic            wake_event,
  output logic            osc_run,
  output logic            sys_clk_enable
);

  logic [7:0] port_zero_data;
  logic [7:0] port_one_data;
  logic [7:0] port_zero_drive_mode;
  logic [7:0] port_one_drive_mode;
  logic [7:0] port_zero_input_mode;
  logic [7:0] port_one_input_mode;
  logic [7:0] port_zero_compare_value;
  logic [7:0] port_one_compare_value;
  logic [7:0] port_zero_compare_mask;
  logic [7:0] port_one_compare_mask;
  logic [7:0] extended_irq_enable_two;
  logic [1:0] osc_enable;
  logic [2:0] osc_divide;
  logic [7:0] port_zero_level;
  logic [7:0] port_one_level;
  logic       port_zero_mismatch;
  logic       port_one_mismatch;
  logic       osc_suspended;
  logic       suspend_req;
  logic       match_irq_enable;
  logic [7:0] next_rdata;

  // Byte write replaces the register; a bit write on a bit-addressable address
  // patches one bit of the stored value, which is the latch-side modify step.
  function automatic logic [7:0] upd(input logic [7:0] old, input logic [7:0] addr);
    logic [7:0] res;
    res = old;
    if (sfr_wr && sfr_addr == addr) begin
      res = sfr_wdata; // R2
    end else if (sfr_bit_wr && sfr_addr == addr && addr[2:0] == 3'h0) begin
      res[sfr_bit_sel] = sfr_bit_val; // R2 R5
    end
    return res;
  endfunction : upd

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      port_zero_data <= RST_PORT_DATA;
      port_one_data  <= RST_PORT_DATA;
    end else begin
      port_zero_data <= upd(port_zero_data, ADDR_PORT_ZERO_DATA); // R3
      port_one_data  <= upd(port_one_data, ADDR_PORT_ONE_DATA); // R3
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      port_zero_drive_mode <= RST_DRIVE_MODE;
      port_one_drive_mode  <= RST_DRIVE_MODE;
      port_zero_input_mode <= RST_INPUT_MODE;
      port_one_input_mode  <= RST_INPUT_MODE;
    end else begin
      port_zero_drive_mode <= upd(port_zero_drive_mode, ADDR_PORT_ZERO_DRIVE_MODE);
      port_one_drive_mode  <= upd(port_one_drive_mode, ADDR_PORT_ONE_DRIVE_MODE);
      port_zero_input_mode <= upd(port_zero_input_mode, ADDR_PORT_ZERO_INPUT_MODE);
      port_one_input_mode  <= upd(port_one_input_mode, ADDR_PORT_ONE_INPUT_MODE);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      port_zero_compare_value <= RST_COMPARE_VALUE;
      port_one_compare_value  <= RST_COMPARE_VALUE;
      port_zero_compare_mask  <= RST_COMPARE_MASK;
      port_one_compare_mask   <= RST_COMPARE_MASK;
    end else begin
      port_zero_compare_value <= upd(port_zero_compare_value, ADDR_PORT_ZERO_COMPARE_VALUE);
      port_one_compare_value  <= upd(port_one_compare_value, ADDR_PORT_ONE_COMPARE_VALUE);
      port_zero_compare_mask  <= upd(port_zero_compare_mask, ADDR_PORT_ZERO_COMPARE_MASK);
      port_one_compare_mask   <= upd(port_one_compare_mask, ADDR_PORT_ONE_COMPARE_MASK);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      extended_irq_enable_two <= RST_IRQ_ENABLE;
    end else begin
      extended_irq_enable_two <= upd(extended_irq_enable_two, ADDR_EXTENDED_IRQ_ENABLE_TWO);
    end
  end

  // The oscillator control register is byte-only; its suspend bit lives in the controller.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      osc_enable <= RST_OSC_ENABLE;
      osc_divide <= RST_OSC_DIVIDE;
    end else if (sfr_wr && sfr_addr == ADDR_INTERNAL_OSC_CONTROL) begin
      osc_enable <= sfr_wdata[OSC_ENABLE_LSB +: 2];
      osc_divide <= sfr_wdata[OSC_DIVIDE_WIDTH-1:0];
    end
  end

  assign suspend_req = sfr_wr && sfr_addr == ADDR_INTERNAL_OSC_CONTROL && sfr_wdata[OSC_SUSPEND_BIT]; // R12

  gpio_port_bank u_port_zero (
    .core_clk      (core_clk),
    .rst           (rst),
    .pin_in        (port_zero_pin_in),
    .latch         (port_zero_data),
    .drive_mode    (port_zero_drive_mode),
    .input_mode    (port_zero_input_mode),
    .compare_value (port_zero_compare_value),
    .compare_mask  (port_zero_compare_mask),
    .xbar_claim    (port_zero_xbar_claim),
    .xbar_out      (port_zero_xbar_out),
    .xbar_oe       (port_zero_xbar_oe),
    .pin_out       (port_zero_pin_out),
    .pin_oe        (port_zero_pin_oe),
    .pin_level     (port_zero_level),
    .mismatch      (port_zero_mismatch)
  );

  gpio_port_bank u_port_one (
    .core_clk      (core_clk),
    .rst           (rst),
    .pin_in        (port_one_pin_in),
    .latch         (port_one_data),
    .drive_mode    (port_one_drive_mode),
    .input_mode    (port_one_input_mode),
    .compare_value (port_one_compare_value),
    .compare_mask  (port_one_compare_mask),
    .xbar_claim    (port_one_xbar_claim),
    .xbar_out      (port_one_xbar_out),
    .xbar_oe       (port_one_xbar_oe),
    .pin_out       (port_one_pin_out),
    .pin_oe        (port_one_pin_oe),
    .pin_level     (port_one_level),
    .mismatch      (port_one_mismatch)
  );

  suspend_wake_ctrl u_suspend (
    .core_clk           (core_clk),
    .rst                (rst),
    .suspend_req        (suspend_req),
    .osc_enable         (osc_enable),
    .osc_is_system_clock      (osc_is_system_clock),
    .port_zero_mismatch (port_zero_mismatch),
    .port_one_mismatch  (port_one_mismatch),
    .cmp_enable         (cmp_enable),
    .cmp_out_pin        (cmp_out_pin),
    .osc_suspended      (osc_suspended),
    .wake_event         (wake_event),
    .osc_run            (osc_run),
    .sys_clk_enable     (sys_clk_enable)
  );

  assign match_event      = port_zero_mismatch | port_one_mismatch; // R8
  assign match_irq_enable = extended_irq_enable_two[MATCH_IRQ_ENABLE_BIT];
  assign match_irq        = match_event & match_irq_enable; // R10

  always_comb begin
    next_rdata = 8'h00;
    case (sfr_addr)
      ADDR_PORT_ZERO_DATA:          next_rdata = sfr_rmw ? port_zero_data : port_zero_level; // R4 R5
      ADDR_PORT_ONE_DATA:           next_rdata = sfr_rmw ? port_one_data : port_one_level; // R4 R5
      ADDR_PORT_ZERO_DRIVE_MODE:    next_rdata = port_zero_drive_mode;
      ADDR_PORT_ONE_DRIVE_MODE:     next_rdata = port_one_drive_mode;
      ADDR_PORT_ZERO_INPUT_MODE:    next_rdata = port_zero_input_mode;
      ADDR_PORT_ONE_INPUT_MODE:     next_rdata = port_one_input_mode;
      ADDR_PORT_ZERO_COMPARE_VALUE: next_rdata = port_zero_compare_value;
      ADDR_PORT_ONE_COMPARE_VALUE:  next_rdata = port_one_compare_value;
      ADDR_PORT_ZERO_COMPARE_MASK:  next_rdata = port_zero_compare_mask;
      ADDR_PORT_ONE_COMPARE_MASK:   next_rdata = port_one_compare_mask;
      ADDR_EXTENDED_IRQ_ENABLE_TWO: next_rdata = extended_irq_enable_two;
      ADDR_INTERNAL_OSC_CONTROL:    next_rdata = {osc_enable, osc_suspended, osc_run, 1'b0, osc_divide};
      default:                      next_rdata = 8'h00;
    endcase
  end

  // Read data is registered and held, so the core samples it one cycle after the strobe.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sfr_rdata <= RST_READ_DATA;
    end else if (sfr_rd) begin
      sfr_rdata <= next_rdata;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  property p_latch_hold;
    !((sfr_wr || sfr_bit_wr) && sfr_addr == ADDR_PORT_ZERO_DATA) |=> $stable(port_zero_data);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("port zero latch changed without a write"); // R3

  property p_byte_write;
    sfr_wr && sfr_addr == ADDR_PORT_ONE_DATA |=> port_one_data == $past(sfr_wdata);
  endproperty
  a_byte_write: assert property (p_byte_write) else $error("byte write not stored in port one"); // R2

  property p_bit_write;
    sfr_bit_wr && !sfr_wr && sfr_addr == ADDR_PORT_ZERO_DATA
      |=> port_zero_data[$past(sfr_bit_sel)] == $past(sfr_bit_val);
  endproperty
  a_bit_write: assert property (p_bit_write) else $error("bit write not stored in port zero"); // R2 R5

  property p_rmw_read;
    sfr_rd && sfr_rmw && sfr_addr == ADDR_PORT_ZERO_DATA |=> sfr_rdata == $past(port_zero_data);
  endproperty
  a_rmw_read: assert property (p_rmw_read) else $error("rmw read did not return the latch"); // R5

  property p_pin_read;
    sfr_rd && !sfr_rmw && sfr_addr == ADDR_PORT_ONE_DATA
      |=> sfr_rdata == ($past(u_port_one.pin_sync) & $past(port_one_input_mode));
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("plain read did not return pin levels"); // R4 R7

  property p_drive_low;
    sfr_wr && sfr_addr == ADDR_PORT_ZERO_DATA && sfr_wdata == 8'h00
      && port_zero_input_mode == 8'hff && port_zero_xbar_claim == 8'h00
      |=> port_zero_pin_oe == 8'hff && port_zero_pin_out == 8'h00;
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("zero in latch did not drive pins low"); // R6

  property p_irq_gate;
    !match_irq_enable |-> !match_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("match interrupt while disabled"); // R10

  property p_match_wake;
    osc_suspended && match_event && !suspend_req |=> !osc_suspended && sys_clk_enable;
  endproperty
  a_match_wake: assert property (p_match_wake) else $error("port match did not wake oscillator"); // R11 R14

  property p_suspend;
    suspend_req && !osc_suspended |=> osc_suspended && !osc_run && (sys_clk_enable == !osc_is_system_clock);
  endproperty
  a_suspend: assert property (p_suspend) else $error("suspend write did not halt oscillator"); // R12 R15

  property p_cmp_wake;
    (cmp_enable && !cmp_out_pin && !suspend_req)[*3] |=> !osc_suspended;
  endproperty
  a_cmp_wake: assert property (p_cmp_wake) else $error("comparator low did not wake oscillator"); // R13

  property p_match_sync;
    port_zero_compare_mask == 8'hff && port_zero_compare_value == 8'h00
      && $past(port_zero_compare_mask) == 8'hff && $past(port_zero_compare_value) == 8'h00
      ##0 $past(port_zero_pin_in, 2) != 8'h00 |-> port_zero_mismatch;
  endproperty
  a_match_sync: assert property (p_match_sync) else $error("mismatch not seen two cycles after pins"); // R9 R16

  c_suspend_wake: cover property (osc_suspended ##1 !osc_suspended);
  c_rmw_read:     cover property (sfr_rd && sfr_rmw && sfr_addr == ADDR_PORT_ONE_DATA);
  c_match_irq:    cover property (match_irq);
  c_cmp_wake:     cover property (osc_suspended && cmp_enable ##1 !osc_suspended);

endmodule : gpio_port_match_wake

// file: tb/pin_pad_model.sv
// Pad model for one 8-bit port: resolves design drive, outside drive and weak pull-up.
// Assumes the testbench supplies the outside drive of each pin.
module pin_pad_model (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // A released pin goes to the pull-up level, so a missing drive reads high and never as a stale value.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) begin
        pin_level[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_level[i] = ext_val[i];
      end else begin
        pin_level[i] = 1'b1;
      end
    end
  end
endmodule : pin_pad_model

// file: tb/testbench.sv
// Self-checking bench for the two-port block with pattern match and suspend wake.
// Assumes pad models on both ports and a bench acting as core and crossbar.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import gpio_match_pkg::*;
  logic       core_clk = 1'b0, rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_rmw = 1'b0;
  logic       sfr_bit_wr = 1'b0, sfr_bit_val = 1'b0, cmp_enable = 1'b0, cmp_out_pin = 1'b1;
  logic       osc_is_system_clock = 1'b1, match_event, match_irq, wake_event, osc_run, sys_clk_enable;
  logic [2:0] sfr_bit_sel = 3'h0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, d;
  logic [7:0] p0_in, p0_out, p0_oe, p1_in, p1_out, p1_oe, ext0_en = 8'h00, ext1_en = 8'h00;
  logic [7:0] ext1_val = 8'h00, claim1 = 8'h00, xout1 = 8'h00, xoe1 = 8'h00;
  int         err_count = 0;
  int         check_count = 0;

  always #2 core_clk = ~core_clk;

  gpio_port_match_wake dut_u (.core_clk(core_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_rmw(sfr_rmw), .sfr_wdata(sfr_wdata), .sfr_bit_wr(sfr_bit_wr),
    .sfr_bit_sel(sfr_bit_sel), .sfr_bit_val(sfr_bit_val), .sfr_rdata(sfr_rdata),
    .port_zero_pin_in(p0_in), .port_zero_pin_out(p0_out), .port_zero_pin_oe(p0_oe),
    .port_one_pin_in(p1_in), .port_one_pin_out(p1_out), .port_one_pin_oe(p1_oe),
    .port_zero_xbar_claim(8'h00), .port_zero_xbar_out(8'h00), .port_zero_xbar_oe(8'h00),
    .port_one_xbar_claim(claim1), .port_one_xbar_out(xout1), .port_one_xbar_oe(xoe1),
    .cmp_enable(cmp_enable), .cmp_out_pin(cmp_out_pin), .osc_is_system_clock(osc_is_system_clock),
    .match_event(match_event), .match_irq(match_irq), .wake_event(wake_event), .osc_run(osc_run),
    .sys_clk_enable(sys_clk_enable));
  pin_pad_model pad0_u (.pin_out(p0_out), .pin_oe(p0_oe), .ext_en(ext0_en), .ext_val(8'h00), .pin_level(p0_in));
  pin_pad_model pad1_u (.pin_out(p1_out), .pin_oe(p1_oe), .ext_en(ext1_en), .ext_val(ext1_val), .pin_level(p1_in));

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_byte

  task automatic chk_bit(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    sfr_addr  <= a;
    sfr_wdata <= v;
    sfr_wr    <= 1'b1;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
    #1;
  endtask : wr_reg

  task automatic bit_wr(input logic [7:0] a, input logic [2:0] s, input logic v);
    @(posedge core_clk);
    sfr_addr    <= a;
    sfr_bit_sel <= s;
    sfr_bit_val <= v;
    sfr_bit_wr  <= 1'b1;
    @(posedge core_clk);
    sfr_bit_wr <= 1'b0;
    #1;
  endtask : bit_wr

  task automatic rd_reg(input logic [7:0] a, input logic m, output logic [7:0] v);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_rmw  <= m;
    sfr_rd   <= 1'b1;
    @(posedge core_clk);
    sfr_rd  <= 1'b0;
    sfr_rmw <= 1'b0;
    #1 v = sfr_rdata;
  endtask : rd_reg

  // Two synchroniser stages plus one edge of margin before pins are trusted.
  task automatic settle;
    repeat (3) @(posedge core_clk);
    #1;
  endtask : settle

  task automatic wait_wake;
    for (int n = 0; n < 8 && sys_clk_enable !== 1'b1; n++) begin
      @(posedge core_clk);
      #1;
    end
    chk_bit("wake clock", 1'b1, sys_clk_enable);
    chk_bit("wake osc", 1'b1, osc_run);
  endtask : wait_wake

  task automatic test_reset;
    chk_byte("reset oe", 8'h00, p0_oe);
    rd_reg(ADDR_PORT_ONE_DATA, 1'b1, d);
    chk_byte("reset latch one", 8'hff, d);
    rd_reg(ADDR_INTERNAL_OSC_CONTROL, 1'b0, d);
    chk_byte("reset osc", 8'hd0, d);
    rd_reg(8'h81, 1'b0, d);
    chk_byte("unmapped", 8'h00, d);
  endtask : test_reset

  task automatic test_latch;
    wr_reg(ADDR_PORT_ZERO_DATA, 8'h5a);
    chk_byte("open drain oe", 8'ha5, p0_oe);
    chk_byte("latch out", 8'h5a, p0_out);
    settle();
    rd_reg(ADDR_PORT_ZERO_DATA, 1'b0, d);
    chk_byte("pin read", 8'h5a, d);
    wr_reg(ADDR_PORT_ZERO_DRIVE_MODE, 8'hff);
    chk_byte("push pull oe", 8'hff, p0_oe);
    repeat (5) @(posedge core_clk);
    #1 chk_byte("latch holds", 8'h5a, p0_out);
  endtask : test_latch

  task automatic test_bits;
    bit_wr(ADDR_PORT_ZERO_DATA, 3'h0, 1'b1);
    bit_wr(ADDR_PORT_ZERO_DATA, 3'h3, 1'b0);
    chk_byte("bit written", 8'h53, p0_out);
    bit_wr(ADDR_PORT_ZERO_DRIVE_MODE, 3'h1, 1'b0);
    rd_reg(ADDR_PORT_ZERO_DRIVE_MODE, 1'b0, d);
    chk_byte("bit write ignored", 8'hff, d);
    wr_reg(ADDR_PORT_ZERO_INPUT_MODE, 8'h0f);
    chk_byte("analog not driven", 8'h0f, p0_oe);
    settle();
    rd_reg(ADDR_PORT_ZERO_DATA, 1'b0, d);
    chk_byte("analog reads zero", 8'h03, d);
    rd_reg(ADDR_PORT_ZERO_DATA, 1'b1, d);
    chk_byte("rmw reads latch", 8'h53, d);
    wr_reg(ADDR_PORT_ZERO_INPUT_MODE, 8'hff);
    wr_reg(ADDR_PORT_ZERO_COMPARE_MASK, 8'hff);
    chk_bit("zero match", 1'b1, match_event);
    wr_reg(ADDR_PORT_ZERO_DATA, 8'h00);
    chk_byte("drive low oe", 8'hff, p0_oe);
    chk_byte("drive low out", 8'h00, p0_out);
    settle();
    chk_bit("zero no match", 1'b0, match_event);
    wr_reg(ADDR_PORT_ZERO_COMPARE_MASK, 8'h00);
  endtask : test_bits

  task automatic test_match;
    @(posedge core_clk);
    claim1  <= 8'h01;
    xoe1    <= 8'h01;
    ext1_en <= 8'hf0;
    settle();
    chk_byte("claimed oe", 8'h01, p1_oe);
    rd_reg(ADDR_PORT_ONE_DATA, 1'b0, d);
    chk_byte("claimed pin read", 8'h0e, d);
    rd_reg(ADDR_PORT_ONE_DATA, 1'b1, d);
    chk_byte("claimed latch", 8'hff, d);
    wr_reg(ADDR_PORT_ONE_COMPARE_VALUE, 8'h01);
    wr_reg(ADDR_PORT_ONE_COMPARE_MASK, 8'h01);
    chk_bit("match", 1'b1, match_event);
    chk_bit("irq masked", 1'b0, match_irq);
    wr_reg(ADDR_EXTENDED_IRQ_ENABLE_TWO, 8'h02);
    chk_bit("irq enabled", 1'b1, match_irq);
    wr_reg(ADDR_EXTENDED_IRQ_ENABLE_TWO, 8'h00);
    wr_reg(ADDR_PORT_ONE_COMPARE_MASK, 8'h00);
    chk_bit("no match", 1'b0, match_event);
    @(posedge core_clk);
    claim1  <= 8'h00;
    xoe1    <= 8'h00;
    ext1_en <= 8'h00;
    settle();
  endtask : test_match

  task automatic test_suspend;
    wr_reg(ADDR_PORT_ONE_COMPARE_VALUE, 8'h80);
    wr_reg(ADDR_PORT_ONE_COMPARE_MASK, 8'h80);
    wr_reg(ADDR_INTERNAL_OSC_CONTROL, 8'he0);
    chk_bit("suspend osc", 1'b0, osc_run);
    repeat (4) @(posedge core_clk);
    #1 chk_bit("suspend clock", 1'b0, sys_clk_enable);
    rd_reg(ADDR_INTERNAL_OSC_CONTROL, 1'b0, d);
    chk_byte("suspend reads", 8'he0, d);
    @(posedge core_clk);
    ext1_en <= 8'h80;
    wait_wake();
    chk_bit("port wake", 1'b1, wake_event);
    chk_bit("wake without irq", 1'b0, match_irq);
    rd_reg(ADDR_INTERNAL_OSC_CONTROL, 1'b0, d);
    chk_byte("awake reads", 8'hd0, d);
    @(posedge core_clk);
    ext1_en <= 8'h00;
    wr_reg(ADDR_PORT_ONE_COMPARE_MASK, 8'h00);
    wr_reg(ADDR_INTERNAL_OSC_CONTROL, 8'he0);
    chk_bit("suspend again", 1'b0, osc_run);
    @(posedge core_clk);
    cmp_enable  <= 1'b1;
    cmp_out_pin <= 1'b0;
    wait_wake();
    chk_bit("comparator wake", 1'b1, wake_event);
    @(posedge core_clk);
    cmp_enable  <= 1'b0;
    cmp_out_pin <= 1'b1;
  endtask : test_suspend

  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    test_reset();
    test_latch();
    test_bits();
    test_match();
    test_suspend();
    stop_test();
  end

  // The tests need well under two thousand cycles; a hang is cut off at twenty thousand.
  initial begin
    #80000;
    err_count++;
    stop_test();
  end
endmodule : testbench
